// *** rtl/input_filter.sv ***
// Synchroniser and debounce filter for the eight opto-isolated input terminals
`default_nettype none
module input_filter
  import motor_io_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] raw,
  output logic      [7:0] clean
);
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_bit
    logic [11:0] cnt_reg;
    always_ff @(posedge clk) begin
      if (reset) begin
        cnt_reg  <= 12'h000;
        clean[i] <= 1'b0;
      end else if (sync2_reg[i] == clean[i]) begin
        cnt_reg <= 12'h000;
      end else if (cnt_reg == 12'(DEBOUNCE_CYCLES - 1)) begin
        cnt_reg  <= 12'h000;
        clean[i] <= sync2_reg[i];
      end else begin
        cnt_reg <= cnt_reg + 12'h001;
      end
    end
  end
endmodule // input_filter
`default_nettype wire

// *** rtl/motor_io_ctrl.sv ***
// Motor drive control-input decoding, speed command ramp and status outputs
// Summary of operation
// - An input is ON while its photocoupler conducts, regardless of voltage.
// - Direction OFF turns clockwise, ON counterclockwise, taken only while the speed command is zero.
// - Stop request ON stops the motor by the selected stop method.
// - Stop mode OFF decelerates at the set rate; ON uses electric braking.
// - Braking stop shorts all three motor phases together.
// - A decelerating stop may regenerate and raise the supply-high alarm.
// - Motor is energized while enable is ON and no alarm is latched, de-energized otherwise.
// - Enable OFF overrides every other input as an emergency stop.
// - Disabling then re-enabling the drive clears its alarm state.
// - Speed source OFF picks the internal setting, ON the analog input.
// - Three preset bits pick one of eight speeds; code zero follows the speed source.
// - External analog speed applies only with presets OFF and source ON.
// - Fault output flags heat, current, voltage faults; active level set.
// - Speed pulses default six per pole pair per turn, count adjustable.
// - Motion output is asserted while the motor rotates.
// - Speed-reached asserts within a window, 0 to 400 rpm, default 200.
// - Overload output asserts above a programmable load level.
// - Warning follows communication error or back-EMF over range.
// - Torque-limit output is ON while torque sits at the limit.
// - LED: steady green disabled, flashing enabled, red/green error codes.
// - Internal speed spans 150 to 4500 rpm; ramps 0 to 3000 rps2.
// - Acceleration and deceleration apply to every speed source.
// - Each input function can be mapped onto any of eight terminals.
// - Each of two output terminals can carry any of eight functions.
`default_nettype none
module motor_io_ctrl
  import motor_io_pkg::*;
#(
  parameter int unsigned RAMP_CYCLES = RAMP_TICK_CYCLES,
  parameter int unsigned LED_CYCLES  = LED_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  in_terminal,
  input  wire logic [12:0] pot_speed_rpm,
  input  wire logic [12:0] analog_speed_rpm,
  input  wire logic [12:0] actual_speed_rpm,
  input  wire logic        hall_edge,
  input  wire logic [7:0]  load_level,
  input  wire logic        torque_at_limit,
  input  wire logic        over_temp,
  input  wire logic        bad_internal_voltage,
  input  wire logic        supply_high,
  input  wire logic        supply_low,
  input  wire logic        over_current,
  input  wire logic        open_phase,
  input  wire logic        bad_hall,
  input  wire logic        comm_error,
  input  wire logic        bemf_over_range,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic      [1:0]  out_terminal,
  output logic      [12:0] speed_cmd_rpm,
  output logic             dir_ccw,
  output logic             energize,
  output logic             phase_short,
  output logic             led_red,
  output logic             led_green
);
  // Clamp a speed into [lo, hi]
  function automatic logic [12:0] clamp13(input logic [12:0] v, input logic [12:0] lo,
                                          input logic [12:0] hi);
    clamp13 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Limit a written value to a ceiling
  function automatic logic [11:0] limit12(input logic [11:0] v, input logic [11:0] hi);
    limit12 = (v > hi) ? hi : v;
  endfunction

  logic [7:0]  term_clean;
  logic [7:0]  func;
  logic [1:0]  ctrl_reg;
  logic [23:0] in_map_reg;
  logic [5:0]  out_map_reg;
  logic [8:0]  reach_win_reg;
  logic [7:0]  ovl_lvl_reg;
  logic [7:0]  pulse_div_reg;
  logic [11:0] accel_reg;
  logic [11:0] decel_reg;
  logic [12:0] spd_min_reg;
  logic [12:0] spd_max_reg;
  logic [12:0] preset_reg [1:7];
  logic [AL_COUNT-1:0] alarm_reg;
  logic [AL_COUNT-1:0] alarm_in;
  logic        en_prev_reg;
  logic [31:0] ramp_cnt_reg;
  logic        ramp_tick;
  logic [12:0] target_rpm;
  logic [12:0] selected_rpm;
  logic [2:0]  preset_code;
  logic        run_ok;
  logic        brake_stop;
  logic [7:0]  pulse_cnt_reg;
  logic        speed_pulse_reg;
  logic        fault_any;
  logic [12:0] speed_diff;
  logic [7:0]  out_func;
  logic        err_valid;
  logic [2:0]  err_red;
  logic [1:0]  err_green;

  // Input conditioning
  input_filter u_filter (
    .clk   (clk),
    .reset (reset),
    .raw   (in_terminal),
    .clean (term_clean)
  );

  for (genvar f = 0; f < 8; f++) begin : g_in_map
    assign func[f] = term_clean[in_map_reg[3*f +: 3]];
  end

  assign preset_code = func[FN_PRESET +: 3];

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg      <= CTRL_RESET;
      in_map_reg    <= IN_MAP_RESET;
      out_map_reg   <= OUT_MAP_RESET;
      reach_win_reg <= REACH_WIN_RESET;
      ovl_lvl_reg   <= OVL_LVL_RESET;
      pulse_div_reg <= PULSE_DIV_RESET;
      accel_reg     <= ACC_RESET;
      decel_reg     <= ACC_RESET;
      spd_min_reg   <= SPD_MIN_RESET;
      spd_max_reg   <= SPD_MAX_RESET;
    end else if (wr) begin
      if (addr == CTRL_OFS) begin
        ctrl_reg <= wdata[1:0];
      end else if (addr == IN_MAP_OFS) begin
        in_map_reg <= wdata[23:0];
      end else if (addr == OUT_MAP_OFS) begin
        out_map_reg <= wdata[5:0];
      end else if (addr == REACH_WIN_OFS) begin
        reach_win_reg <= (wdata[8:0] > REACH_WIN_MAX) ? REACH_WIN_MAX : wdata[8:0];
      end else if (addr == OVL_LVL_OFS) begin
        ovl_lvl_reg <= wdata[7:0];
      end else if (addr == PULSE_DIV_OFS) begin
        pulse_div_reg <= (wdata[7:0] == 8'h00) ? 8'h01 : wdata[7:0];
      end else if (addr == ACCEL_OFS) begin
        accel_reg <= limit12(wdata[11:0], ACC_MAX);
      end else if (addr == DECEL_OFS) begin
        decel_reg <= limit12(wdata[11:0], ACC_MAX);
      end else if (addr == RANGE_OFS) begin
        spd_min_reg <= wdata[12:0];
        spd_max_reg <= wdata[RANGE_MAX_LSB +: 13];
      end
    end
  end

  for (genvar p = 1; p < 8; p++) begin : g_preset
    always_ff @(posedge clk) begin
      if (reset) begin
        preset_reg[p] <= PRESET_RESET[p];
      end else if (wr && addr == PRESET_OFS + 8'(4 * p)) begin
        preset_reg[p] <= wdata[12:0];
      end
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset || !rd) begin
      rdata <= 32'h0000_0000;
    end else if (addr == CTRL_OFS) begin
      rdata <= {30'h0000_0000, ctrl_reg};
    end else if (addr == IN_MAP_OFS) begin
      rdata <= {8'h00, in_map_reg};
    end else if (addr == OUT_MAP_OFS) begin
      rdata <= {26'h000_0000, out_map_reg};
    end else if (addr == REACH_WIN_OFS) begin
      rdata <= {23'h00_0000, reach_win_reg};
    end else if (addr == OVL_LVL_OFS) begin
      rdata <= {24'h00_0000, ovl_lvl_reg};
    end else if (addr == PULSE_DIV_OFS) begin
      rdata <= {24'h00_0000, pulse_div_reg};
    end else if (addr == ACCEL_OFS) begin
      rdata <= {20'h0_0000, accel_reg};
    end else if (addr == DECEL_OFS) begin
      rdata <= {20'h0_0000, decel_reg};
    end else if (addr == RANGE_OFS) begin
      rdata <= {3'h0, spd_max_reg, 3'h0, spd_min_reg};
    end else if (addr == STATUS_OFS) begin
      rdata <= {10'h000, out_terminal, 4'h0, alarm_reg, func};
    end else if (addr == SPEED_OFS) begin
      rdata <= {3'h0, actual_speed_rpm, 3'h0, speed_cmd_rpm};
    end else if (addr[7:5] == PRESET_OFS[7:5] && addr[1:0] == 2'h0 && addr[4:2] != 3'h0) begin
      rdata <= {19'h0_0000, preset_reg[addr[4:2]]};
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // Alarms latch; cleared by an enable OFF-to-ON sequence
  assign alarm_in[AL_TEMP]  = over_temp;
  assign alarm_in[AL_INTV]  = bad_internal_voltage;
  assign alarm_in[AL_VHIGH] = supply_high;
  assign alarm_in[AL_VLOW]  = supply_low;
  assign alarm_in[AL_CURR]  = over_current;
  assign alarm_in[AL_LOAD]  = (load_level > ovl_lvl_reg);
  assign alarm_in[AL_PHASE] = open_phase;
  assign alarm_in[AL_HALL]  = bad_hall;

  always_ff @(posedge clk) begin
    if (reset) begin
      en_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= func[FN_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alarm_reg <= '0;
    end else if (func[FN_EN] && !en_prev_reg) begin
      alarm_reg <= alarm_in;
    end else begin
      alarm_reg <= alarm_reg | alarm_in;
    end
  end

  // Speed selection
  always_comb begin
    if (preset_code != 3'h0) begin
      selected_rpm = preset_reg[preset_code];
    end else if (func[FN_SRC]) begin
      selected_rpm = clamp13(analog_speed_rpm, 13'h0000, spd_max_reg);
    end else begin
      selected_rpm = clamp13(pot_speed_rpm, spd_min_reg, spd_max_reg);
    end
  end

  assign run_ok     = func[FN_EN] && (alarm_reg == '0);
  assign brake_stop = func[FN_STOP] && func[FN_STOP_MODE];
  assign target_rpm = (run_ok && !func[FN_STOP]) ? selected_rpm : 13'h0000;

  // Ramp timebase: one tick per 1/60 s, so rps2 equals rpm per tick
  assign ramp_tick = (ramp_cnt_reg == RAMP_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (reset || ramp_tick) begin
      ramp_cnt_reg <= 32'h0000_0000;
    end else begin
      ramp_cnt_reg <= ramp_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      speed_cmd_rpm <= 13'h0000;
    end else if (!func[FN_EN] || (brake_stop && run_ok)) begin
      speed_cmd_rpm <= 13'h0000;
    end else if (ramp_tick) begin
      if (speed_cmd_rpm < target_rpm) begin
        speed_cmd_rpm <= (target_rpm - speed_cmd_rpm > {1'b0, accel_reg})
                         ? speed_cmd_rpm + {1'b0, accel_reg} : target_rpm;
      end else if (speed_cmd_rpm > target_rpm) begin
        speed_cmd_rpm <= (speed_cmd_rpm - target_rpm > {1'b0, decel_reg})
                         ? speed_cmd_rpm - {1'b0, decel_reg} : target_rpm;
      end
    end
  end

  // Power stage controls
  always_ff @(posedge clk) begin
    if (reset) begin
      energize    <= 1'b0;
      phase_short <= 1'b0;
      dir_ccw     <= 1'b0;
    end else begin
      energize    <= run_ok;
      phase_short <= run_ok && brake_stop;
      if (speed_cmd_rpm == 13'h0000) begin
        dir_ccw <= func[FN_DIR];
      end
    end
  end

  // Speed pulse divider on hall transitions
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_cnt_reg   <= 8'h00;
      speed_pulse_reg <= 1'b0;
    end else begin
      speed_pulse_reg <= 1'b0;
      if (hall_edge) begin
        if (pulse_cnt_reg >= pulse_div_reg - 8'h01) begin
          pulse_cnt_reg   <= 8'h00;
          speed_pulse_reg <= 1'b1;
        end else begin
          pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
        end
      end
    end
  end

  // Output function selection
  assign fault_any = alarm_reg[AL_TEMP] | alarm_reg[AL_INTV] | alarm_reg[AL_VHIGH]
                   | alarm_reg[AL_VLOW] | alarm_reg[AL_CURR];
  assign speed_diff = (actual_speed_rpm > target_rpm) ? actual_speed_rpm - target_rpm
                                                     : target_rpm - actual_speed_rpm;

  assign out_func[OF_FAULT]    = fault_any ~^ ctrl_reg[CTRL_FAULT_HIGH_BIT];
  assign out_func[OF_SPEED]    = speed_pulse_reg;
  assign out_func[OF_MOVE]     = (actual_speed_rpm != 13'h0000);
  assign out_func[OF_REACHED]  = (speed_diff <= {4'h0, reach_win_reg});
  assign out_func[OF_OVERLOAD] = alarm_reg[AL_LOAD];
  assign out_func[OF_WARNING]  = comm_error | bemf_over_range;
  assign out_func[OF_TORQUE]   = torque_at_limit;
  assign out_func[OF_IDLE]     = ctrl_reg[CTRL_IDLE_BIT];

  for (genvar t = 0; t < 2; t++) begin : g_out_map
    always_ff @(posedge clk) begin
      if (reset) begin
        out_terminal[t] <= 1'b0;
      end else begin
        out_terminal[t] <= out_func[out_map_reg[3*t +: 3]];
      end
    end
  end

  // Blink code of the highest-priority alarm, else of a communication error
  always_comb begin
    err_valid = 1'b1;
    err_red   = 3'h0;
    err_green = 2'h0;
    if (alarm_reg[AL_TEMP]) begin
      err_red = 3'h3; err_green = 2'h1;
    end else if (alarm_reg[AL_INTV]) begin
      err_red = 3'h3; err_green = 2'h2;
    end else if (alarm_reg[AL_VHIGH]) begin
      err_red = 3'h4; err_green = 2'h1;
    end else if (alarm_reg[AL_VLOW]) begin
      err_red = 3'h4; err_green = 2'h2;
    end else if (alarm_reg[AL_CURR]) begin
      err_red = 3'h5; err_green = 2'h1;
    end else if (alarm_reg[AL_LOAD]) begin
      err_red = 3'h5; err_green = 2'h2;
    end else if (alarm_reg[AL_PHASE]) begin
      err_red = 3'h6; err_green = 2'h1;
    end else if (alarm_reg[AL_HALL]) begin
      err_red = 3'h6; err_green = 2'h2;
    end else if (comm_error) begin
      err_red = 3'h7; err_green = 2'h1;
    end else begin
      err_valid = 1'b0;
    end
  end

  status_led #(
    .TICK_CYCLES (LED_CYCLES)
  ) u_led (
    .clk         (clk),
    .reset       (reset),
    .enabled     (run_ok),
    .err_valid   (err_valid),
    .red_count   (err_red),
    .green_count (err_green),
    .led_red     (led_red),
    .led_green   (led_green)
  );
endmodule // motor_io_ctrl
`default_nettype wire

// *** rtl/motor_io_pkg.sv ***
// Package: register map, defaults and timing of the motor I/O control block
`default_nettype none
package motor_io_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_NS = 10;
  // Timing
  localparam int unsigned DEBOUNCE_NS      = 20_000;
  localparam int unsigned DEBOUNCE_CYCLES  = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RAMP_TICK_NS     = 16_666_667;
  localparam int unsigned RAMP_TICK_CYCLES = (RAMP_TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LED_TICK_NS      = 250_000_000;
  localparam int unsigned LED_TICK_CYCLES  = LED_TICK_NS / CLK_NS;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] IN_MAP_OFS   = 8'h04;
  localparam logic [7:0] OUT_MAP_OFS  = 8'h08;
  localparam logic [7:0] REACH_WIN_OFS = 8'h0C;
  localparam logic [7:0] OVL_LVL_OFS  = 8'h10;
  localparam logic [7:0] PULSE_DIV_OFS = 8'h14;
  localparam logic [7:0] ACCEL_OFS    = 8'h18;
  localparam logic [7:0] DECEL_OFS    = 8'h1C;
  localparam logic [7:0] RANGE_OFS    = 8'h20;
  localparam logic [7:0] STATUS_OFS   = 8'h24;
  localparam logic [7:0] SPEED_OFS    = 8'h28;
  localparam logic [7:0] PRESET_OFS   = 8'h40;
  // Field positions
  localparam int unsigned CTRL_FAULT_HIGH_BIT = 0;
  localparam int unsigned CTRL_IDLE_BIT       = 1;
  localparam int unsigned RANGE_MAX_LSB       = 16;
  localparam int unsigned STAT_ALARM_LSB      = 8;
  localparam int unsigned STAT_OUT_LSB        = 20;
  localparam int unsigned SPEED_ACT_LSB       = 16;
  // Reset values and limits
  localparam logic [1:0]  CTRL_RESET      = 2'h1;
  localparam logic [23:0] IN_MAP_RESET    = 24'hFA_C688;
  localparam logic [5:0]  OUT_MAP_RESET   = 6'h08;
  localparam logic [8:0]  REACH_WIN_RESET = 9'h0C8;
  localparam logic [8:0]  REACH_WIN_MAX   = 9'h190;
  localparam logic [7:0]  OVL_LVL_RESET   = 8'hC8;
  localparam logic [7:0]  PULSE_DIV_RESET = 8'h01;
  localparam logic [11:0] ACC_RESET       = 12'hBB8;
  localparam logic [11:0] ACC_MAX         = 12'hBB8;
  localparam logic [12:0] SPD_MIN_RESET   = 13'h0096;
  localparam logic [12:0] SPD_MAX_RESET   = 13'h1194;
  localparam logic [12:0] PRESET_RESET [1:7] = '{13'h01F4, 13'h03E8, 13'h07D0,
                                                 13'h0BB8, 13'h0DAC, 13'h0FA0, 13'h1194};
  // Input functions
  localparam int unsigned FN_DIR = 0;
  localparam int unsigned FN_STOP_MODE = 1;
  localparam int unsigned FN_EN = 2;
  localparam int unsigned FN_SRC = 3;
  localparam int unsigned FN_STOP = 4;
  localparam int unsigned FN_PRESET = 5;
  // Output functions
  typedef enum logic [2:0] {
    OF_FAULT = 3'h0, OF_SPEED = 3'h1, OF_MOVE = 3'h2, OF_REACHED = 3'h3,
    OF_OVERLOAD = 3'h4, OF_WARNING = 3'h5, OF_TORQUE = 3'h6, OF_IDLE = 3'h7
  } out_func_e;
  // Alarm vector bit positions
  localparam int unsigned AL_TEMP = 0;
  localparam int unsigned AL_INTV = 1;
  localparam int unsigned AL_VHIGH = 2;
  localparam int unsigned AL_VLOW = 3;
  localparam int unsigned AL_CURR = 4;
  localparam int unsigned AL_LOAD = 5;
  localparam int unsigned AL_PHASE = 6;
  localparam int unsigned AL_HALL = 7;
  localparam int unsigned AL_COUNT = 8;
  // LED blink sequencer
  typedef enum logic [4:0] {
    LED_IDLE = 5'b00001, LED_RED_ON = 5'b00010, LED_RED_OFF = 5'b00100,
    LED_GRN_ON = 5'b01000, LED_GRN_OFF = 5'b10000
  } led_state_e;
endpackage
`default_nettype wire

// *** rtl/status_led.sv ***
// Status LED sequencer: steady or flashing green, or red/green blink codes
`default_nettype none
module status_led
  import motor_io_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = LED_TICK_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       enabled,
  input  wire logic       err_valid,
  input  wire logic [2:0] red_count,
  input  wire logic [1:0] green_count,
  output logic            led_red,
  output logic            led_green
);
  logic [31:0] div_reg;
  logic        tick;
  led_state_e  state_reg;
  logic [2:0]  left_reg;
  logic [1:0]  grn_reg;

  assign tick = (div_reg == TICK_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (reset || tick) begin
      div_reg <= 32'h0000_0000;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= LED_IDLE;
      left_reg  <= 3'h0;
      grn_reg   <= 2'h0;
      led_red   <= 1'b0;
      led_green <= 1'b1;
    end else if (tick) begin
      case (state_reg)
        LED_IDLE: begin
          led_red <= 1'b0;
          if (err_valid) begin
            state_reg <= LED_RED_ON;
            left_reg  <= red_count;
            grn_reg   <= green_count;
            led_green <= 1'b0;
          end else begin
            led_green <= enabled ? ~led_green : 1'b1;
          end
        end
        LED_RED_ON: begin
          led_red   <= 1'b1;
          left_reg  <= left_reg - 3'h1;
          state_reg <= LED_RED_OFF;
        end
        LED_RED_OFF: begin
          led_red <= 1'b0;
          if (left_reg == 3'h0) begin
            left_reg  <= {1'b0, grn_reg};
            state_reg <= LED_GRN_ON;
          end else begin
            state_reg <= LED_RED_ON;
          end
        end
        LED_GRN_ON: begin
          led_green <= 1'b1;
          left_reg  <= left_reg - 3'h1;
          state_reg <= LED_GRN_OFF;
        end
        LED_GRN_OFF: begin
          led_green <= 1'b0;
          state_reg <= (left_reg == 3'h0) ? LED_IDLE : LED_GRN_ON;
        end
        default: state_reg <= LED_IDLE;
      endcase
    end
  end
endmodule // status_led
`default_nettype wire

// *** sim/motor_io_ctrl_sva.sv ***
// Checker for the motor I/O control block
`default_nettype none
module motor_io_ctrl_sva (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        rd,
  input wire logic        over_temp,
  input wire logic [31:0] rdata,
  input wire logic [12:0] speed_cmd_rpm,
  input wire logic        dir_ccw,
  input wire logic        energize,
  input wire logic        phase_short,
  input wire logic        led_red,
  input wire logic        led_green
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_rdata_idle_zero: assert property (!rd |=> rdata == 32'h0000_0000)
    else $error("read data not zero outside read");
  a_dir_hold_moving: assert property (speed_cmd_rpm != 0 |=> $stable(dir_ccw))
    else $error("direction changed while moving");
  a_brake_stops_cmd: assert property ($rose(phase_short) |-> ##[0:1] speed_cmd_rpm == 0)
    else $error("brake stop left speed command");
  a_brake_needs_power: assert property (phase_short |-> energize)
    else $error("phase short while not energized");
  a_ramp_step_max: assert property (speed_cmd_rpm > $past(speed_cmd_rpm)
    |-> speed_cmd_rpm - $past(speed_cmd_rpm) <= 13'd3000)
    else $error("acceleration step too large");
  a_rise_when_on: assert property (speed_cmd_rpm > $past(speed_cmd_rpm) |-> energize)
    else $error("speed rose while de-energized");
  a_fault_drops_power: assert property (over_temp |-> ##[1:3] !energize)
    else $error("fault did not drop energize");
  a_led_one_colour: assert property (!(led_red && led_green))
    else $error("both LED colours on");
  a_speed_in_range: assert property (speed_cmd_rpm <= 13'd4500)
    else $error("speed command above maximum");
  c_energized: cover property ($rose(energize));
  c_brake: cover property ($rose(phase_short));
  c_preset_one: cover property (speed_cmd_rpm == 13'd500);
endmodule // motor_io_ctrl_sva
bind motor_io_ctrl motor_io_ctrl_sva i_motor_io_ctrl_sva (.clk(clk), .reset(reset), .rd(rd),
  .over_temp(over_temp), .rdata(rdata), .speed_cmd_rpm(speed_cmd_rpm), .dir_ccw(dir_ccw),
  .energize(energize), .phase_short(phase_short), .led_red(led_red), .led_green(led_green));
`default_nettype wire

// *** sim/motor_io_ctrl_tb.sv ***
// Self-checking bench for the motor I/O control block
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module motor_io_ctrl_tb;
  import motor_io_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, reset = 1, wr = 0, rd = 0, over_temp = 0, hall_edge = 0;
  logic        torque = 0, supply_high = 0, comm_error = 0, bemf = 0, led_red, led_green, green_prev;
  logic [12:0] pot_rpm = 13'h0064, ana_rpm = 13'h03E8, act_rpm = 13'h0000;
  logic [7:0]  addr = 0, fn_level = 0, in_terminal, load = 8'h10;
  int          red_seen = 0;
  logic [31:0] wdata = 0, rdata;
  logic [12:0] speed_cmd_rpm;
  logic [1:0]  out_terminal;
  logic        dir_ccw, energize, phase_short;
  int          n_fail = 0, comparisons = 0;
  int          preset_rpm [1:7] = '{500, 1000, 2000, 3000, 3500, 4000, 4500};
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (led_red) red_seen <= red_seen + 1;
  end
  opto_controller i_opto_controller (.clk(clk), .fn_level(fn_level), .in_terminal(in_terminal));
  motor_io_ctrl #(.RAMP_CYCLES(10), .LED_CYCLES(4)) i_motor_io_ctrl (
    .clk(clk), .reset(reset), .in_terminal(in_terminal), .pot_speed_rpm(pot_rpm),
    .analog_speed_rpm(ana_rpm), .actual_speed_rpm(act_rpm), .hall_edge(hall_edge),
    .load_level(load), .torque_at_limit(torque), .over_temp(over_temp),
    .bad_internal_voltage(1'b0), .supply_high(supply_high), .supply_low(1'b0),
    .over_current(1'b0), .open_phase(1'b0), .bad_hall(1'b0), .comm_error(comm_error),
    .bemf_over_range(bemf), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .out_terminal(out_terminal), .speed_cmd_rpm(speed_cmd_rpm), .dir_ccw(dir_ccw),
    .energize(energize), .phase_short(phase_short), .led_red(led_red), .led_green(led_green));
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // Apply function levels and wait out the input filter
  task automatic apply(input logic [7:0] f);
    @(posedge clk);
    fn_level <= f;
    repeat (2100) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd_chk(CTRL_OFS, 32'h0000_0001);
    `CHK({led_red, led_green}, 2'b01)
    rd_chk(REACH_WIN_OFS, 32'h0000_00C8);
    for (int i = 1; i <= 7; i++) rd_chk(PRESET_OFS + 8'(4 * i), 32'(preset_rpm[i]));
    rd_chk(8'h3C, 32'h0000_0000);
    wr_reg(REACH_WIN_OFS, 32'h0000_01F4);
    rd_chk(REACH_WIN_OFS, 32'h0000_0190);
    // Enable, counterclockwise, preset code 001
    apply(8'h25);
    `CHK(energize, 1'b1)
    `CHK(dir_ccw, 1'b1)
    `CHK(speed_cmd_rpm, 13'd500)
    apply(8'h37);
    `CHK(phase_short, 1'b1)
    `CHK(speed_cmd_rpm, 13'd0)
    apply(8'h33);
    `CHK(energize, 1'b0)
    `CHK(phase_short, 1'b0)
    apply(8'h04);
    @(posedge clk);
    over_temp <= 1'b1;
    @(posedge clk);
    over_temp <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK(energize, 1'b0)
    `CHK(out_terminal[0], 1'b1)
    apply(8'h00);
    `CHK(red_seen > 0, 1'b1)
    apply(8'h04);
    `CHK(energize, 1'b1)
    `CHK(out_terminal[0], 1'b0)
    `CHK(dir_ccw, 1'b0)
    `CHK(speed_cmd_rpm, 13'h0096)
    @(posedge clk);
    #1;
    green_prev = led_green;
    repeat (4) @(posedge clk);
    #1;
    `CHK(led_green, ~green_prev)
    // Analog source, then status outputs through the terminal map
    apply(8'h0C);
    `CHK(speed_cmd_rpm, 13'h03E8)
    wr_reg(OUT_MAP_OFS, 32'h0000_002B);
    act_rpm <= 13'h0258;
    comm_error <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(out_terminal, 2'b11)
    @(posedge clk);
    act_rpm <= 13'h0257;
    comm_error <= 1'b0;
    bemf <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(out_terminal, 2'b10)
    wr_reg(OUT_MAP_OFS, 32'h0000_0026);
    bemf <= 1'b0;
    torque <= 1'b1;
    load <= 8'hC9;
    repeat (3) @(posedge clk);
    #1;
    `CHK(out_terminal, 2'b11)
    `CHK(energize, 1'b0)
    wr_reg(PULSE_DIV_OFS, 32'h0000_0003);
    wr_reg(OUT_MAP_OFS, 32'h0000_000A);
    hall_edge <= 1'b1;
    repeat (3) @(posedge clk);
    hall_edge <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(out_terminal, 2'b11)
    @(posedge clk);
    #1;
    `CHK(out_terminal, 2'b01)
    wr_reg(OUT_MAP_OFS, 32'h0000_0000);
    supply_high <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(out_terminal, 2'b11)
    wr_reg(CTRL_OFS, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    `CHK(out_terminal, 2'b00)
    complete_run();
  end
endmodule // motor_io_ctrl_tb
`default_nettype wire

// *** sim/opto_controller.sv ***
// External controller model driving the opto-isolated terminals
`default_nettype none
module opto_controller (
  input  wire logic       clk,
  input  wire logic [7:0] fn_level,
  output logic      [7:0] in_terminal
);
  timeunit 1ns;
  timeprecision 1ps;
  // Identity terminal map; 1 means photocoupler conducting
  always_ff @(posedge clk) begin
    in_terminal <= fn_level;
  end
endmodule // opto_controller
`default_nettype wire
